/* verilog/pusc_consts.vh */
`ifndef PUSC_CONSTS_VH
`define PUSC_CONSTS_VH
// Register byte addresses (index times four)
`define PUSC_IDX_REF_TYPE      8'h0A
`define PUSC_ADR_REF_TYPE      10'h028
`define PUSC_ADR_STRAP_STAT    10'h040
`define PUSC_ADR_OUT_ENABLE    10'h044
`define PUSC_ADR_CLK_STAT      10'h048
// Reset values
`define PUSC_RST_REF_TYPE      8'h01
`define PUSC_RST_OUT_ENABLE    8'h00
// Strap field positions
`define PUSC_STRAP_W           6
`define PUSC_STRAP_CLK_LO      0
`define PUSC_STRAP_BRINGUP     2
`define PUSC_CLKSEL_24M576     2'h3
// Timing
`define PUSC_CLK_MHZ           100
`define PUSC_STRAP_WINDOW_MS   50
`define PUSC_STRAP_WINDOW_CYC  (`PUSC_STRAP_WINDOW_MS * 1000 * `PUSC_CLK_MHZ)
`define PUSC_POR_MIN_MS        2
`define PUSC_POR_MIN_CYC       (`PUSC_POR_MIN_MS * 1000 * `PUSC_CLK_MHZ)
`define PUSC_MON_REF_PPM       8'h00
`endif

/* verilog/pusc_sync3.v */
`timescale 1ns/1ns
`include "pusc_consts.vh"
module pusc_sync3 #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         core_clk,
    input  wire         rst,
    // Data
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge core_clk) begin
                s1_q[i] <= async_in[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                // A change counts only once two late stages agree
                if (rst) begin
                    sync_out[i] <= 1'b0;
                end else if (s2_q[i] == s3_q[i]) begin
                    sync_out[i] <= s3_q[i];
                end
            end
        end
    endgenerate
endmodule // pusc_sync3

/* verilog/pusc_window_timer.v */
`timescale 1ns/1ns
`include "pusc_consts.vh"
module pusc_window_timer #(
    parameter CYCLES = `PUSC_STRAP_WINDOW_CYC
) (
    // Clock and reset
    input  wire core_clk,
    input  wire rst,
    // Control
    input  wire restart,
    output reg  done
);
    localparam [31:0] LAST = CYCLES - 1;
    reg [31:0] cnt_q;
    always @(posedge core_clk) begin
        if (rst || restart) begin
            cnt_q <= 32'h0;
            done  <= 1'b0;
        end else if (!done) begin
            if (cnt_q == LAST) begin
                done <= 1'b1;
            end
            cnt_q <= cnt_q + 32'h1;
        end
    end
endmodule // pusc_window_timer

/* verilog/pusc_top.v */
`timescale 1ns/1ns
`include "pusc_consts.vh"
module pusc_top #(
    parameter STRAP_WINDOW_CYC = `PUSC_STRAP_WINDOW_CYC,
    parameter NUM_OUT          = 8
) (
    // Clock and reset
    input  wire                     core_clk,
    input  wire                     rst,
    // Active-low power-on reset pin
    input  wire                     por_n,
    // General purpose pins
    input  wire [`PUSC_STRAP_W-1:0] gpio_in,
    output reg  [`PUSC_STRAP_W-1:0] gpio_out,
    output reg  [`PUSC_STRAP_W-1:0] gpio_oe,
    // Device status to the rest of the chip
    output reg  [NUM_OUT-1:0]       output_enable,
    output reg  [3:0]               reference_differential,
    output reg                      master_clk_valid,
    output reg                      strap_done,
    output reg  [7:0]               monitor_ref_ppm,
    // Wishbone slave
    input  wire                     wb_cyc_i,
    input  wire                     wb_stb_i,
    input  wire                     wb_we_i,
    input  wire [9:0]               wb_adr_i,
    input  wire [3:0]               wb_sel_i,
    input  wire [31:0]              wb_dat_i,
    output reg  [31:0]              wb_dat_o,
    output reg                      wb_ack_o,
    output reg                      wb_err_o
);
    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    wire                     por_n_s;
    wire [`PUSC_STRAP_W-1:0] gpio_s;
    pusc_sync3 #(.W(`PUSC_STRAP_W + 1)) u_pusc_sync3 (
        .core_clk (core_clk),
        .rst      (rst),
        .async_in ({por_n, gpio_in}),
        .sync_out ({por_n_s, gpio_s})
    );

    // ------------------------------------------------------------
    // Power-on sequencer
    // ------------------------------------------------------------
    localparam [2:0] ST_HELD   = 3'h1;
    localparam [2:0] ST_WINDOW = 3'h2;
    localparam [2:0] ST_RUN    = 3'h4;
    reg  [2:0] state_q;
    reg  [2:0] state_d;
    wire       win_done;
    wire       in_reset = rst || (state_q == ST_HELD);

    // Timer restarts on every reset entry so a short glitch cannot shorten it
    pusc_window_timer #(.CYCLES(STRAP_WINDOW_CYC)) u_pusc_window_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .restart  (state_q != ST_WINDOW),
        .done     (win_done)
    );

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_HELD: begin
                if (por_n_s) begin
                    state_d = ST_WINDOW;
                end
            end
            ST_WINDOW: begin
                if (!por_n_s) begin
                    state_d = ST_HELD;
                end else if (win_done) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!por_n_s) begin
                    state_d = ST_HELD;
                end
            end
            default: begin
                state_d = ST_HELD;
            end
        endcase
    end

    always @(posedge core_clk) begin
        if (rst) begin
            state_q <= ST_HELD;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------
    // Straps are caught once at window end; the pins are free afterwards
    reg  [`PUSC_STRAP_W-1:0] strap_q;
    wire                     latch_now = (state_q == ST_WINDOW) && win_done && por_n_s;
    wire                     run_now   = (state_q == ST_RUN);
    genvar                   n;

    generate
        for (n = 0; n < `PUSC_STRAP_W; n = n + 1) begin : g_strap
            always @(posedge core_clk) begin
                if (in_reset) begin
                    strap_q[n] <= 1'b0;
                end else if (latch_now) begin
                    strap_q[n] <= gpio_s[n];
                end
            end
        end
    endgenerate

    wire [1:0] clk_sel = strap_q[`PUSC_STRAP_CLK_LO+1:`PUSC_STRAP_CLK_LO];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [7:0]               ref_type_q;
    reg  [7:0]               out_en_q;
    reg  [`PUSC_STRAP_W-1:0] gpio_dout_q;
    reg  [`PUSC_STRAP_W-1:0] gpio_dir_q;
    reg                      hit;
    reg  [31:0]              rdata;

    // Write strobes, one per register
    wire                     wb_req      = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire                     wb_wr       = wb_req && wb_we_i && wb_sel_i[0];
    wire                     wr_ref_type = wb_wr && (wb_adr_i == `PUSC_ADR_REF_TYPE);
    wire                     wr_out_en   = wb_wr && (wb_adr_i == `PUSC_ADR_OUT_ENABLE);
    wire                     wr_gpio_dir = wr_out_en && wb_sel_i[1];
    wire                     wr_clk_stat = wb_wr && (wb_adr_i == `PUSC_ADR_CLK_STAT);

    // Read mux; an unmapped address answers with an error and reads zero
    always @* begin
        hit   = 1'b1;
        rdata = 32'h0;
        case (wb_adr_i)
            `PUSC_ADR_REF_TYPE: begin
                rdata = {24'h0, ref_type_q};
            end
            `PUSC_ADR_STRAP_STAT: begin
                rdata = {18'h0, gpio_s, 2'h0, strap_q};
            end
            `PUSC_ADR_OUT_ENABLE: begin
                rdata = {18'h0, gpio_dir_q, out_en_q};
            end
            `PUSC_ADR_CLK_STAT: begin
                rdata = {24'h0, gpio_dout_q, master_clk_valid, strap_done};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // A reset or a held power-on pin wins over a write in the same cycle
    always @(posedge core_clk) begin
        if (in_reset) begin
            ref_type_q <= `PUSC_RST_REF_TYPE;
        end else if (wr_ref_type) begin
            ref_type_q <= wb_dat_i[7:0];
        end
    end

    always @(posedge core_clk) begin
        if (in_reset) begin
            out_en_q <= `PUSC_RST_OUT_ENABLE;
        end else if (wr_out_en) begin
            out_en_q <= wb_dat_i[7:0];
        end
    end

    // Direction bits need their own byte lane so a plain enable write keeps them
    always @(posedge core_clk) begin
        if (in_reset) begin
            gpio_dir_q <= {`PUSC_STRAP_W{1'b0}};
        end else if (wr_gpio_dir) begin
            gpio_dir_q <= wb_dat_i[8+`PUSC_STRAP_W-1:8];
        end
    end

    always @(posedge core_clk) begin
        if (in_reset) begin
            gpio_dout_q <= {`PUSC_STRAP_W{1'b0}};
        end else if (wr_clk_stat) begin
            gpio_dout_q <= wb_dat_i[2+`PUSC_STRAP_W-1:2];
        end
    end

    // Bus answers one cycle after the request; ack drops the next cycle so
    // a master that is slow to release stb is not answered twice
    always @(posedge core_clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req && hit;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            wb_err_o <= 1'b0;
        end else begin
            wb_err_o <= wb_req && !hit;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            wb_dat_o <= 32'h0;
        end else begin
            wb_dat_o <= (wb_req && hit && !wb_we_i) ? rdata : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    localparam [7:0] REF_RST = `PUSC_RST_REF_TYPE;

    // Status follows the sequencer one cycle late, as every output is a flop
    always @(posedge core_clk) begin
        if (in_reset) begin
            strap_done <= 1'b0;
        end else begin
            strap_done <= run_now;
        end
    end

    always @(posedge core_clk) begin
        if (in_reset) begin
            master_clk_valid <= 1'b0;
        end else begin
            master_clk_valid <= run_now && (clk_sel == `PUSC_CLKSEL_24M576);
        end
    end

    // Master clock is the measuring reference, so its own offset is zero
    always @(posedge core_clk) begin
        if (in_reset) begin
            monitor_ref_ppm <= `PUSC_MON_REF_PPM;
        end else begin
            monitor_ref_ppm <= `PUSC_MON_REF_PPM;
        end
    end

    generate
        // Only output zero answers the bring-up strap; software cannot
        // turn it off again until the next power-on reset
        for (n = 0; n < NUM_OUT; n = n + 1) begin : g_out
            wire bringup = (n == 0) ? strap_q[`PUSC_STRAP_BRINGUP] : 1'b0;
            always @(posedge core_clk) begin
                if (in_reset) begin
                    output_enable[n] <= 1'b0;
                end else if (run_now) begin
                    output_enable[n] <= out_en_q[n] | bringup;
                end else begin
                    output_enable[n] <= 1'b0;
                end
            end
        end

        // Each reference keeps its own mode flag
        for (n = 0; n < 4; n = n + 1) begin : g_ref
            always @(posedge core_clk) begin
                if (in_reset) begin
                    reference_differential[n] <= REF_RST[n];
                end else begin
                    reference_differential[n] <= ref_type_q[n];
                end
            end
        end

        // Pins stay inputs until the window ends so straps are never fought
        for (n = 0; n < `PUSC_STRAP_W; n = n + 1) begin : g_pin
            always @(posedge core_clk) begin
                if (in_reset || !run_now) begin
                    gpio_out[n] <= 1'b0;
                    gpio_oe[n]  <= 1'b0;
                end else begin
                    gpio_out[n] <= gpio_dout_q[n];
                    gpio_oe[n]  <= gpio_dir_q[n];
                end
            end
        end
    endgenerate
endmodule // pusc_top

/* tb/pusc_top_chk.sv */
`timescale 1ns/1ns
// ------------------------------
// Port checker
// ------------------------------
module pusc_top_chk #(parameter NUM_OUT = 8) (
    input wire               core_clk,
    input wire               rst,
    input wire               por_n,
    input wire [NUM_OUT-1:0] output_enable,
    input wire [5:0]         gpio_oe,
    input wire [3:0]         reference_differential,
    input wire               master_clk_valid,
    input wire               strap_done,
    input wire [7:0]         monitor_ref_ppm,
    input wire               wb_cyc_i,
    input wire               wb_stb_i,
    input wire               wb_ack_o,
    input wire               wb_err_o
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    outs_off_a: assert property (!strap_done |-> output_enable == 0) else $error("output on early");
    gpio_idle_a: assert property (!strap_done |-> gpio_oe == 0) else $error("gpio driven early");
    valid_run_a: assert property (master_clk_valid |-> strap_done) else $error("clock valid early");
    ppm_zero_a: assert property (monitor_ref_ppm == 8'h00) else $error("monitor offset not zero");
    ref_dflt_a: assert property ($fell(rst) |-> reference_differential == 4'h1) else $error("bad ref default");
    por_clear_a: assert property (!por_n [*8] |-> !strap_done && output_enable == 0)
        else $error("por low not clearing");
    bus_answer_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> (wb_ack_o || wb_err_o))
        else $error("late bus answer");
    ack_pulse_a: assert property ((wb_ack_o || wb_err_o) |=> !(wb_ack_o || wb_err_o)) else $error("long answer");
    err_excl_a: assert property (wb_err_o |-> !wb_ack_o) else $error("ack with err");
endmodule // pusc_top_chk
bind pusc_top pusc_top_chk #(.NUM_OUT(NUM_OUT)) u_pusc_top_chk (.core_clk(core_clk), .rst(rst), .por_n(por_n),
    .output_enable(output_enable), .gpio_oe(gpio_oe), .reference_differential(reference_differential),
    .master_clk_valid(master_clk_valid), .strap_done(strap_done), .monitor_ref_ppm(monitor_ref_ppm),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o));

/* tb/pusc_board.sv */
`timescale 1ns/1ns
// ------------------------------
// Board reset and strap driver
// ------------------------------
module pusc_board #(parameter POR_LOW = 16, parameter HOLD = 40) (
    input  wire       core_clk,
    input  wire       start,
    input  wire [5:0] strap,
    output reg        por_n   = 1'b0,
    output reg  [5:0] gpio_in = 6'h00
);
    integer cnt = 0;
    reg     busy = 1'b0;
    always @(posedge core_clk) begin
        if (start) begin
            busy <= 1'b1;
            cnt <= 0;
            por_n <= 1'b0;
            gpio_in <= strap;
        end else if (busy) begin
            cnt <= cnt + 1;
            if (cnt == POR_LOW) por_n <= 1'b1;
            if (cnt == POR_LOW + HOLD) busy <= 1'b0;
        end else begin
            // Released pins toggle so a stale value never looks like a strap
            gpio_in <= ~gpio_in;
        end
    end
endmodule // pusc_board

/* tb/powerup_strap_config_tb_top.sv */
`timescale 1ns/1ns
`include "pusc_consts.vh"
// ------------------------------
// Testbench
// ------------------------------
module powerup_strap_config_tb_top;
    reg         core_clk = 1'b0, rst = 1'b1, start = 1'b0, bus_err;
    reg         wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    reg  [5:0]  strap = 6'h00;
    reg  [9:0]  wb_adr_i = 10'h000;
    reg  [3:0]  wb_sel_i = 4'h0;
    reg  [31:0] wb_dat_i = 32'h0, rd;
    reg  [5:0]  tbl [0:4];
    wire        por_n, master_clk_valid, strap_done, wb_ack_o, wb_err_o;
    wire [5:0]  gpio_in, gpio_out, gpio_oe;
    wire [7:0]  output_enable, monitor_ref_ppm;
    wire [3:0]  reference_differential;
    wire [31:0] wb_dat_o;
    integer     err_count = 0, n_compared = 0, i;
    always #5 core_clk = ~core_clk;
    pusc_board u_pusc_board (.core_clk(core_clk), .start(start), .strap(strap), .por_n(por_n), .gpio_in(gpio_in));
    pusc_top #(.STRAP_WINDOW_CYC(20)) u_pusc_top (.core_clk(core_clk), .rst(rst), .por_n(por_n), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .output_enable(output_enable),
        .reference_differential(reference_differential), .master_clk_valid(master_clk_valid),
        .strap_done(strap_done), .monitor_ref_ppm(monitor_ref_ppm), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o));
    task complete_run;
        begin
            if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // Bounded wait at rising edges: sel high waits for the window end, low for a bus answer
    task wait_hi(input sel, input integer lim);
        integer k;
        begin
            k = 0;
            @(posedge core_clk);
            while ((sel ? strap_done : (wb_ack_o | wb_err_o)) !== 1'b1 && k < lim) begin
                @(posedge core_clk);
                k = k + 1;
            end
            if (k == lim) begin
                err_count = err_count + 1;
                complete_run;
            end
        end
    endtask
    // Data is taken in the cycle of the answer, released at the edge that samples it
    task wb(input w, input [9:0] a, input [3:0] s, input [31:0] d);
        begin
            @(posedge core_clk);
            {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, s, d};
            wait_hi(1'b0, 20);
            rd = wb_dat_o;
            bus_err = wb_err_o;
            {wb_cyc_i, wb_stb_i} <= 2'b00;
        end
    endtask
    task t_strap(input [5:0] v);
        begin
            @(posedge core_clk);
            strap <= v;
            start <= 1'b1;
            @(posedge core_clk);
            start <= 1'b0;
            repeat (8) @(posedge core_clk);
            wait_hi(1'b1, 200);
            chk(master_clk_valid, v[1:0] == `PUSC_CLKSEL_24M576);
            chk(output_enable, {7'h0, v[2]});
            repeat (50) @(posedge core_clk);
            wb(1'b0, `PUSC_ADR_STRAP_STAT, 4'hF, 32'h0);
            chk(rd[5:0], v);
            wb(1'b0, `PUSC_ADR_REF_TYPE, 4'hF, 32'h0);
            chk(rd, `PUSC_RST_REF_TYPE);
        end
    endtask
    task t_regs;
        begin
            wb(1'b1, `PUSC_ADR_REF_TYPE, 4'h1, 32'h0E);
            wb(1'b1, `PUSC_ADR_REF_TYPE, 4'h0, 32'h05);
            wb(1'b0, `PUSC_ADR_REF_TYPE, 4'hF, 32'h0);
            chk(rd, 32'h0E);
            wb(1'b1, `PUSC_ADR_OUT_ENABLE, 4'h3, 32'h3F02);
            wb(1'b1, `PUSC_ADR_CLK_STAT, 4'h1, 32'hA8);
            @(negedge core_clk);
            chk(reference_differential, 4'hE);
            chk(output_enable, 8'h03);
            chk({gpio_oe, gpio_out}, 12'hFEA);
            wb(1'b0, `PUSC_ADR_CLK_STAT, 4'hF, 32'h0);
            chk(rd, 32'hAB);
            wb(1'b0, 10'h3FC, 4'hF, 32'h0);
            chk(bus_err, 1'b1);
        end
    endtask
    task t_por;
        begin
            @(posedge core_clk);
            start <= 1'b1;
            @(posedge core_clk);
            start <= 1'b0;
            repeat (10) @(negedge core_clk);
            chk({strap_done, output_enable}, 9'h000);
            chk(reference_differential, 4'h1);
            chk(monitor_ref_ppm, `PUSC_MON_REF_PPM);
        end
    endtask
    initial begin
        tbl[0] = 6'h03;
        tbl[1] = 6'h04;
        tbl[2] = 6'h29;
        tbl[3] = 6'h36;
        tbl[4] = 6'h3F;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        for (i = 0; i < 5; i = i + 1) t_strap(tbl[i]);
        t_regs;
        t_por;
        complete_run;
    end
endmodule // powerup_strap_config_tb_top
